// ---- pkg/adc_seq_defs.svh ----
// Register offsets, field positions, reset values and timing counts of the converter sequencer.
`ifndef ADC_SEQ_DEFS_SVH
`define ADC_SEQ_DEFS_SVH

`define REG_CTRL0 4'h0
`define REG_CTRL1 4'h1
`define REG_EXT1 4'h2
`define REG_EXT2 4'h3
`define REG_DELAY 4'h4
`define REG_RES_HI 4'h5
`define REG_RES_LO 4'h6
`define REG_HBND_HI 4'h7
`define REG_HBND_LO 4'h8
`define REG_LBND_HI 4'h9
`define REG_LBND_LO 4'hA
`define REG_INT 4'hB
`define REG_PIN_LO 4'hC
`define REG_PIN_HI 4'hD

`define CTRL0_START 7
`define CTRL0_BUSY 6
`define CTRL0_ENABLE 5
`define EXT1_FORMAT 7
`define EXT1_ABOVE 1
`define EXT1_BELOW 0
`define EXT2_TRIG 0
`define EXT2_PWM_SRC 1
`define EXT2_DLY_EN 2
`define INT_GLOBAL 0
`define INT_CONV_IE 1
`define INT_BOUND_IE 2
`define INT_MF_IE 3
`define INT_CONV_FLAG 4
`define INT_BOUND_FLAG 5

`define REG_RESET 8'h00
`define SRC_EXT 3'h0
`define SRC_AMP 3'h1
`define NUM_CHANNELS 4'hA
`define SAMPLE_TICKS 4'h4
`define CONVERT_TICKS 4'hC
`define TOTAL_TICKS 12'h010

`endif

// ---- pkg/adc_seq_pkg.sv ----
// Types shared by the converter sequencer, the analog front end and the testbench.
package adc_seq_pkg;
    typedef enum logic [1:0] {IDLE, SAMPLE, CONVERT} conv_state_e;
    typedef struct packed {
        logic [9:0] ext_sel;
        logic ext_en;
        logic amp_sel;
        logic gnd_sel;
    } mux_s;
    typedef struct packed {
        logic [9:0] pullup_req;
        logic [9:0] dir_in_req;
        logic [9:0] other_req;
    } pin_req_s;
    typedef struct packed {
        logic [9:0] analog_en;
        logic [9:0] pullup_en;
        logic [9:0] dir_in;
        logic [9:0] other_en;
    } pin_s;
endpackage

// ---- verilog/adc_clock_divider.sv ----
// Converter clock enable generator: one-cycle tick every 2^sel system clocks.
`timescale 1ns/10ps
module adc_clock_divider (
    input wire logic clk, // System clock.
    input wire logic srst, // Synchronous reset, active high.
    input wire logic restart, // Realigns the divider to a conversion start.
    input wire logic [2:0] div_sel, // Division ratio code.
    output logic tick // One-cycle converter clock enable.
);
    logic [6:0] cnt;
    logic [6:0] mask;

    assign mask = 7'((8'h01 << div_sel) - 8'h01);
    assign tick = (cnt & mask) == mask;

    always_ff @(posedge clk) begin
        if (srst || restart) begin
            cnt <= 7'h00;
        end else begin
            cnt <= cnt + 7'h01;
        end
    end
endmodule

// ---- verilog/adc_sequencer.sv ----
// Input selection, pin override, start triggering and conversion sequencing of the converter.
`timescale 1ns/10ps
`include "adc_seq_defs.svh"
module adc_sequencer (
    input wire logic clk, // System clock, 200 MHz.
    input wire logic srst, // Synchronous reset, active high.
    input wire logic [3:0] addr, // Register address.
    input wire logic [7:0] wdata, // Register write data.
    input wire logic wr, // Write strobe.
    input wire logic rd, // Read strobe.
    output logic [7:0] rdata, // Read data, valid the cycle after rd.
    input wire adc_seq_pkg::pin_req_s pin_req, // Software pin settings.
    output adc_seq_pkg::pin_s pin_out, // Effective pin controls.
    output adc_seq_pkg::mux_s mux, // Analog input multiplexer controls.
    input wire logic pwm_period_flag, // PWM period interrupt flag.
    input wire logic pwm_duty_flag, // PWM duty interrupt flag.
    input wire logic [11:0] conv_data, // Converter output code.
    output logic sampling, // Sample phase active.
    output logic converting, // Conversion phase active.
    output logic converter_tick, // Converter clock enable, one cycle.
    output logic irq_conversion, // Conversion-done interrupt request.
    output logic irq_bound // Boundary interrupt request.
);
    import adc_seq_pkg::*;

    logic [7:0] converter_control_zero;
    logic [7:0] converter_control_one;
    logic [7:0] converter_control_ext_one;
    logic [7:0] converter_control_ext_two;
    logic [7:0] trigger_delay_count;
    logic [7:0] bound_hi_h;
    logic [7:0] bound_hi_l;
    logic [7:0] bound_lo_h;
    logic [7:0] bound_lo_l;
    logic [7:0] int_ctrl;
    logic [7:0] pin_function_select_low;
    logic [7:0] pin_function_select_high;
    logic [11:0] result;
    conv_state_e state;
    logic [3:0] phase;
    logic conversion_busy_flag;
    logic start_prev;
    logic pwm_prev;
    logic dly_run;
    logic [7:0] dly_cnt;
    logic run_amp;
    logic tick;
    logic go;
    logic done;
    logic [7:0] read_mux;
    logic [9:0] analog_pins;
    logic [2:0] input_source_field;
    logic [3:0] external_channel_field;
    logic converter_enable_bit;
    logic trigger_source_select;
    logic pwm_trigger_source_select;
    logic trigger_delay_enable;
    logic result_format_select;
    logic pwm_sel;
    logic pwm_edge;
    logic sw_start;
    logic hw_now;
    logic dly_go;
    logic src_amp;
    logic src_gnd;
    logic src_ext;
    logic above_hit;
    logic below_hit;
    logic bound_set;
    logic conv_clr;
    logic bound_clr;

    // Aligned register view of a 12-bit value: left or right justified.
    function automatic logic [15:0] align(input logic [11:0] v, input logic fmt);
        align = fmt ? {4'h0, v} : {v, 4'h0};
    endfunction

    // Recovers a 12-bit value from its two register bytes under the format bit.
    function automatic logic [11:0] unalign(input logic [7:0] h, input logic [7:0] l,
                                            input logic fmt);
        unalign = fmt ? {h[3:0], l} : {h, l[7:4]};
    endfunction

    assign input_source_field = converter_control_one[7:5];
    assign external_channel_field = converter_control_zero[3:0];
    assign converter_enable_bit = converter_control_zero[`CTRL0_ENABLE];
    assign trigger_source_select = converter_control_ext_two[`EXT2_TRIG];
    assign pwm_trigger_source_select = converter_control_ext_two[`EXT2_PWM_SRC];
    assign trigger_delay_enable = converter_control_ext_two[`EXT2_DLY_EN];
    assign result_format_select = converter_control_ext_one[`EXT1_FORMAT];
    assign analog_pins = {pin_function_select_high[1:0], pin_function_select_low};

    assign src_amp = input_source_field == `SRC_AMP;
    assign src_gnd = input_source_field[2:1] == 2'b01;
    assign src_ext = !src_amp && !src_gnd;

    assign pwm_sel = pwm_trigger_source_select ? pwm_duty_flag : pwm_period_flag;
    assign pwm_edge = pwm_sel && !pwm_prev;
    // A start pulse is the start bit falling after having been high.
    assign sw_start = !trigger_source_select && start_prev
                      && !converter_control_zero[`CTRL0_START];
    assign hw_now = trigger_source_select && pwm_edge
                    && !(trigger_delay_enable && trigger_delay_count != 8'h00);
    assign dly_go = dly_run && dly_cnt == 8'h01;
    assign go = converter_enable_bit && state == IDLE
                && (sw_start || hw_now || dly_go);
    assign done = state == CONVERT && tick && phase == `CONVERT_TICKS - 4'h1;

    // True when a code lies above the high boundary decoded under the format bit.
    function automatic logic result_in_bounds_hi(input logic [11:0] v);
        result_in_bounds_hi = v > unalign(bound_hi_h, bound_hi_l, result_format_select);
    endfunction

    assign above_hit = result_in_bounds_hi(conv_data);
    assign below_hit = conv_data < unalign(bound_lo_h, bound_lo_l, result_format_select);
    assign bound_set = done && run_amp
        && ((converter_control_ext_one[`EXT1_ABOVE] && above_hit)
        || (converter_control_ext_one[`EXT1_BELOW] && below_hit));
    assign conv_clr = wr && addr == `REG_INT && wdata[`INT_CONV_FLAG];
    assign bound_clr = wr && addr == `REG_INT && wdata[`INT_BOUND_FLAG];

    adc_clock_divider u_div (
        .clk(clk),
        .srst(srst),
        .restart(go),
        .div_sel(converter_control_one[2:0]),
        .tick(tick)
    );

    // Software-written registers.
    always_ff @(posedge clk) begin
        if (srst) begin
            converter_control_zero <= `REG_RESET;
            converter_control_one <= `REG_RESET;
            converter_control_ext_one <= `REG_RESET;
            converter_control_ext_two <= `REG_RESET;
            trigger_delay_count <= `REG_RESET;
            bound_hi_h <= `REG_RESET;
            bound_hi_l <= `REG_RESET;
            bound_lo_h <= `REG_RESET;
            bound_lo_l <= `REG_RESET;
            pin_function_select_low <= `REG_RESET;
            pin_function_select_high <= `REG_RESET;
        end else if (wr) begin
            if (addr == `REG_CTRL0) begin
                converter_control_zero <= wdata;
            end else if (addr == `REG_CTRL1) begin
                converter_control_one <= wdata;
            end else if (addr == `REG_EXT1) begin
                converter_control_ext_one <= wdata;
            end else if (addr == `REG_EXT2) begin
                converter_control_ext_two <= wdata;
            end else if (addr == `REG_DELAY) begin
                trigger_delay_count <= wdata;
            end else if (addr == `REG_HBND_HI) begin
                bound_hi_h <= wdata;
            end else if (addr == `REG_HBND_LO) begin
                bound_hi_l <= wdata;
            end else if (addr == `REG_LBND_HI) begin
                bound_lo_h <= wdata;
            end else if (addr == `REG_LBND_LO) begin
                bound_lo_l <= wdata;
            end else if (addr == `REG_PIN_LO) begin
                pin_function_select_low <= wdata;
            end else if (addr == `REG_PIN_HI) begin
                pin_function_select_high <= {6'h00, wdata[1:0]};
            end
        end
    end

    // Interrupt enables and sticky flags; a hardware set wins over a clear.
    always_ff @(posedge clk) begin
        if (srst) begin
            int_ctrl <= `REG_RESET;
        end else begin
            if (wr && addr == `REG_INT) begin
                int_ctrl[3:0] <= wdata[3:0];
            end
            int_ctrl[`INT_CONV_FLAG] <= done || (int_ctrl[`INT_CONV_FLAG] && !conv_clr);
            int_ctrl[`INT_BOUND_FLAG] <= bound_set
                || (int_ctrl[`INT_BOUND_FLAG] && !bound_clr);
        end
    end

    // Gated interrupt requests.
    always_ff @(posedge clk) begin
        if (srst) begin
            irq_conversion <= 1'b0;
            irq_bound <= 1'b0;
        end else begin
            irq_conversion <= int_ctrl[`INT_GLOBAL] && int_ctrl[`INT_CONV_IE]
                && int_ctrl[`INT_MF_IE] && int_ctrl[`INT_CONV_FLAG];
            irq_bound <= int_ctrl[`INT_GLOBAL] && int_ctrl[`INT_BOUND_IE]
                && int_ctrl[`INT_MF_IE] && int_ctrl[`INT_BOUND_FLAG];
        end
    end

    // Trigger edge history and the PWM start delay.
    always_ff @(posedge clk) begin
        if (srst) begin
            start_prev <= 1'b0;
            pwm_prev <= 1'b0;
            dly_run <= 1'b0;
            dly_cnt <= 8'h00;
        end else begin
            start_prev <= converter_control_zero[`CTRL0_START];
            pwm_prev <= pwm_sel;
            if (!converter_enable_bit || !trigger_source_select || dly_go) begin
                dly_run <= 1'b0;
            end else if (dly_run) begin
                dly_cnt <= dly_cnt - 8'h01;
            end else if (pwm_edge && trigger_delay_enable && state == IDLE
                         && trigger_delay_count != 8'h00) begin
                dly_run <= 1'b1;
                dly_cnt <= trigger_delay_count;
            end
        end
    end

    // Sample and convert sequence, counted in converter clock ticks.
    always_ff @(posedge clk) begin
        if (srst) begin
            state <= IDLE;
            phase <= 4'h0;
            conversion_busy_flag <= 1'b0;
            sampling <= 1'b0;
            converting <= 1'b0;
            run_amp <= 1'b0;
            result <= 12'h000;
        end else if (!converter_enable_bit) begin
            state <= IDLE;
            conversion_busy_flag <= 1'b0;
            sampling <= 1'b0;
            converting <= 1'b0;
        end else begin
            case (state)
                IDLE: begin
                    if (go) begin
                        state <= SAMPLE;
                        phase <= 4'h0;
                        conversion_busy_flag <= 1'b1;
                        sampling <= 1'b1;
                        run_amp <= src_amp;
                    end
                end
                SAMPLE: begin
                    if (tick) begin
                        if (phase == `SAMPLE_TICKS - 4'h1) begin
                            state <= CONVERT;
                            phase <= 4'h0;
                            sampling <= 1'b0;
                            converting <= 1'b1;
                        end else begin
                            phase <= phase + 4'h1;
                        end
                    end
                end
                CONVERT: begin
                    if (done) begin
                        state <= IDLE;
                        conversion_busy_flag <= 1'b0;
                        converting <= 1'b0;
                        result <= conv_data;
                    end else if (tick) begin
                        phase <= phase + 4'h1;
                    end
                end
                default: begin
                    state <= IDLE;
                end
            endcase
        end
    end

    // Input multiplexer and pin-function override.
    always_ff @(posedge clk) begin
        if (srst) begin
            mux <= '0;
            pin_out <= '0;
            converter_tick <= 1'b0;
        end else begin
            mux.amp_sel <= src_amp;
            mux.gnd_sel <= src_gnd;
            mux.ext_en <= src_ext && external_channel_field < `NUM_CHANNELS;
            mux.ext_sel <= (src_ext && external_channel_field < `NUM_CHANNELS)
                ? 10'(11'h001 << external_channel_field) : 10'h000;
            pin_out.analog_en <= analog_pins;
            pin_out.other_en <= pin_req.other_req & ~analog_pins;
            pin_out.pullup_en <= pin_req.pullup_req & ~analog_pins;
            pin_out.dir_in <= pin_req.dir_in_req | analog_pins;
            converter_tick <= tick && state != IDLE;
        end
    end

    // Register read path: data stand only in the cycle after the strobe.
    always_comb begin
        logic [15:0] res_al;
        res_al = align(result, result_format_select);
        if (addr == `REG_CTRL0) begin
            read_mux = converter_control_zero;
            read_mux[`CTRL0_BUSY] = conversion_busy_flag;
        end else if (addr == `REG_CTRL1) begin
            read_mux = converter_control_one;
        end else if (addr == `REG_EXT1) begin
            read_mux = converter_control_ext_one;
        end else if (addr == `REG_EXT2) begin
            read_mux = converter_control_ext_two;
        end else if (addr == `REG_DELAY) begin
            read_mux = trigger_delay_count;
        end else if (addr == `REG_RES_HI) begin
            read_mux = res_al[15:8];
        end else if (addr == `REG_RES_LO) begin
            read_mux = res_al[7:0];
        end else if (addr == `REG_HBND_HI) begin
            read_mux = bound_hi_h;
        end else if (addr == `REG_HBND_LO) begin
            read_mux = bound_hi_l;
        end else if (addr == `REG_LBND_HI) begin
            read_mux = bound_lo_h;
        end else if (addr == `REG_LBND_LO) begin
            read_mux = bound_lo_l;
        end else if (addr == `REG_INT) begin
            read_mux = int_ctrl;
        end else if (addr == `REG_PIN_LO) begin
            read_mux = pin_function_select_low;
        end else if (addr == `REG_PIN_HI) begin
            read_mux = pin_function_select_high;
        end else begin
            read_mux = 8'h00;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rdata <= 8'h00;
        end else begin
            rdata <= rd ? read_mux : 8'h00;
        end
    end

    // Helper: cycles spent busy and the divider code in force.
    logic [11:0] busy_cycles;
    logic [2:0] div_run;
    always_ff @(posedge clk) begin
        if (srst) begin
            busy_cycles <= 12'h000;
            div_run <= 3'h0;
        end else if (go) begin
            busy_cycles <= 12'h000;
            div_run <= converter_control_one[2:0];
        end else if (conversion_busy_flag) begin
            busy_cycles <= busy_cycles + 12'h001;
        end
    end

    a_busy_length:
    assert property (@(posedge clk) disable iff (srst)
        $fell(conversion_busy_flag) && $past(converter_enable_bit)
        |-> busy_cycles == 12'(`TOTAL_TICKS << div_run))
        else $error("conversion length differs from sixteen converter clocks");
    a_busy_ignore:
    assert property (@(posedge clk) disable iff (srst)
        conversion_busy_flag && (sw_start || hw_now || dly_go) |=> busy_cycles != 12'h000)
        else $error("trigger restarted a running conversion");
    a_enable_gate:
    assert property (@(posedge clk) disable iff (srst)
        $rose(conversion_busy_flag) |-> $past(converter_enable_bit))
        else $error("conversion began with converter disabled");
    a_amp_exclusive:
    assert property (@(posedge clk) disable iff (srst)
        mux.amp_sel || mux.gnd_sel |-> mux.ext_sel == 10'h000 && !mux.ext_en)
        else $error("external path on while internal source selected");
    a_float_code:
    assert property (@(posedge clk) disable iff (srst)
        src_ext && external_channel_field >= `NUM_CHANNELS |=> mux.ext_sel == 10'h000)
        else $error("nonexistent channel drove a select line");
    a_ground_src:
    assert property (@(posedge clk) disable iff (srst)
        input_source_field == 3'h2 || input_source_field == 3'h3 |=> mux.gnd_sel)
        else $error("ground not selected");
    a_pin_override:
    assert property (@(posedge clk) disable iff (srst)
        (pin_out.analog_en & (pin_out.other_en | pin_out.pullup_en | ~pin_out.dir_in))
        == 10'h000)
        else $error("analog pin kept another function");
    a_irq_gate:
    assert property (@(posedge clk) disable iff (srst)
        irq_bound |-> $past(int_ctrl[`INT_GLOBAL] && int_ctrl[`INT_MF_IE]
        && int_ctrl[`INT_BOUND_FLAG]))
        else $error("boundary interrupt raised without enables");
    a_sample_span:
    assert property (@(posedge clk) disable iff (srst)
        $rose(converting) |-> $past(sampling) && phase == 4'h0)
        else $error("conversion phase did not follow sampling");
endmodule

// ---- tb/analog_front_end.sv ----
// Behavioural analog front end that hands the sequencer a code for the selected input.
`timescale 1ns/10ps
module analog_front_end (
    input wire logic clk, // System clock.
    input wire adc_seq_pkg::mux_s mux, // Input selection.
    input wire logic sampling, // Sample phase.
    input wire logic [11:0] amp_level, // Amplifier output code.
    output logic [11:0] conv_data // Converted code.
);
    import adc_seq_pkg::*;
    logic [11:0] held = 12'h000;
    logic [11:0] drift = 12'h000;
    logic [11:0] pick;
    // A floating input yields a code that changes every cycle.
    always_comb begin
        pick = mux.amp_sel ? amp_level : mux.gnd_sel ? 12'h000 : drift;
        for (int i = 0; i < 10; i++) begin
            if (mux.ext_en && mux.ext_sel[i]) begin
                pick = {i[3:0], 8'h5A};
            end
        end
    end
    always_ff @(posedge clk) begin
        drift <= drift + 12'h9B7;
        if (sampling) begin
            held <= pick;
        end
    end
    assign conv_data = sampling ? drift : held;
endmodule

// ---- tb/tb_top.sv ----
// Self-checking testbench of the converter sequencer.
`timescale 1ns/10ps
`include "adc_seq_defs.svh"
module tb_top;
    import adc_seq_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic pwm_period_flag = 1'b0;
    logic pwm_duty_flag = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic [11:0] amp_level = 12'h800;
    logic [11:0] conv_data;
    pin_req_s pin_req = {10'h3FF, 10'h155, 10'h3FF};
    pin_s pin_out;
    mux_s mux;
    mux_s exp_mux;
    logic sampling, converting, converter_tick, irq_conversion, irq_bound;
    int errors = 0;
    int tests_run = 0;
    int ns, nc, nt, f0, f1;
    // Each row: amplifier code, ext1, interrupt enables, source, expected bound flag.
    logic [35:0] bnd [8] = '{36'h800020F11, 36'h800010F11, 36'h800000F10, 36'h7FF020F10,
        36'h800030F00, 36'h800020711, 36'h800020B11, 36'h800020E11};
    adc_sequencer dut (.clk, .srst, .addr, .wdata, .wr, .rd, .rdata, .pin_req, .pin_out, .mux,
        .pwm_period_flag, .pwm_duty_flag, .conv_data, .sampling, .converting,
        .converter_tick, .irq_conversion, .irq_bound);
    analog_front_end afe (.clk, .mux, .sampling, .amp_level, .conv_data);
    initial forever #2.5 clk = ~clk;
    task automatic chk(input string w, input logic [39:0] e, input logic [39:0] g);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        rd <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rchk(input logic [3:0] a, input logic [7:0] e, input string w);
        addr <= a;
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(w, e, rdata);
        @(posedge clk);
    endtask
    task automatic idle(input int n);
        wr <= 1'b0;
        rd <= 1'b0;
        repeat (n) @(posedge clk);
    endtask
    task automatic measure(output int s, output int c, output int t, output int f);
        int k;
        s = 0;
        c = 0;
        t = 0;
        f = 0;
        for (k = 0; k < 2200; k++) begin
            #1;
            if (s == 0 && sampling === 1'b1)
                f = k;
            s += (sampling === 1'b1);
            c += (converting === 1'b1);
            t += (converter_tick === 1'b1);
            if (s + c > 0 && sampling !== 1'b1 && converting !== 1'b1)
                break;
            @(posedge clk);
        end
        if (k == 2200) begin
            errors++;
            print_verdict();
        end
        @(posedge clk);
    endtask
    task automatic conv(input logic [2:0] dv, input logic [7:0] e1, input logic [2:0] src,
            input logic [3:0] ch);
        wr_reg(`REG_CTRL1, {src, 2'b00, dv});
        wr_reg(`REG_EXT1, e1);
        wr_reg(`REG_CTRL0, {4'hA, ch});
        wr_reg(`REG_CTRL0, {4'h2, ch});
        idle(1);
        measure(ns, nc, nt, f0);
    endtask
    task automatic trig(input logic duty);
        wr <= 1'b0;
        pwm_duty_flag <= duty;
        pwm_period_flag <= !duty;
        @(posedge clk);
        pwm_duty_flag <= 1'b0;
        pwm_period_flag <= 1'b0;
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        for (int a = 0; a < 16; a++) rchk(a[3:0], 8'h00, "reset value");
        wr_reg(4'hE, 8'hFF);
        wr_reg(`REG_CTRL0, 8'h40);
        rchk(4'hE, 8'h00, "unmapped");
        rchk(`REG_CTRL0, 8'h00, "busy write");
        wr_reg(`REG_PIN_LO, 8'h05);
        wr_reg(`REG_PIN_HI, 8'h02);
        idle(2);
        #1 chk("pins", {10'h205, 10'h1FA, 10'h355, 10'h1FA}, pin_out);
        for (int s = 0; s < 8; s++) begin
            for (int c = 0; c < 16; c++) begin
                wr_reg(`REG_CTRL1, {s[2:0], 5'h00});
                wr_reg(`REG_CTRL0, {4'h0, c[3:0]});
                idle(2);
                exp_mux = '0;
                exp_mux.amp_sel = (s == 1);
                exp_mux.gnd_sel = (s == 2 || s == 3);
                exp_mux.ext_en = (s == 0 || s > 3) && c < 10;
                exp_mux.ext_sel = exp_mux.ext_en ? 10'h001 << c : 10'h000;
                #1 chk("mux", exp_mux, mux);
            end
        end
        for (int d = 0; d < 8; d++) begin
            conv(d[2:0], 8'h00, 3'h0, 4'h3);
            chk("sample cycles", 4 << d, ns);
            chk("convert cycles", 12 << d, nc);
            chk("ticks", 16, nt);
        end
        rchk(`REG_RES_HI, 8'h35, "result hi");
        rchk(`REG_RES_LO, 8'hA0, "result lo");
        rchk(`REG_INT, 8'h10, "done flag");
        conv(3'h0, 8'h80, 3'h4, 4'h9);
        rchk(`REG_RES_HI, 8'h09, "result hi");
        rchk(`REG_RES_LO, 8'h5A, "result lo");
        wr_reg(`REG_INT, 8'h30);
        wr_reg(`REG_CTRL0, 8'hA3);
        wr_reg(`REG_CTRL0, 8'h23);
        idle(2);
        rchk(`REG_CTRL0, 8'h63, "busy");
        wr_reg(`REG_CTRL0, 8'h03);
        idle(2);
        #1 chk("abort", 2'b00, {sampling, converting});
        rchk(`REG_INT, 8'h00, "abort flags");
        wr_reg(`REG_CTRL0, 8'h83);
        wr_reg(`REG_CTRL0, 8'h03);
        idle(20);
        #1 chk("disabled start", 1'b0, sampling);
        wr_reg(`REG_HBND_HI, 8'h7F);
        wr_reg(`REG_HBND_LO, 8'hF0);
        wr_reg(`REG_LBND_HI, 8'h80);
        wr_reg(`REG_LBND_LO, 8'h10);
        foreach (bnd[i]) begin
            amp_level <= bnd[i][35:24];
            wr_reg(`REG_INT, bnd[i][15:8] | 8'h30);
            conv(3'h0, bnd[i][23:16], bnd[i][6:4], 4'h0);
            rchk(`REG_INT, {2'b00, bnd[i][0], 1'b1, bnd[i][11:8]}, "flags");
            #1 chk("irq bound", &{bnd[i][0], bnd[i][8], bnd[i][10], bnd[i][11]}, irq_bound);
            chk("irq done", &{bnd[i][8], bnd[i][9], bnd[i][11]}, irq_conversion);
        end
        wr_reg(`REG_CTRL1, 8'h00);
        wr_reg(`REG_EXT2, 8'h01);
        wr_reg(`REG_CTRL0, 8'h23);
        trig(1'b0);
        measure(ns, nc, nt, f0);
        chk("pwm start", 4, ns);
        wr_reg(`REG_DELAY, 8'h05);
        wr_reg(`REG_EXT2, 8'h05);
        trig(1'b0);
        measure(ns, nc, nt, f1);
        chk("delay", 5, f1 - f0);
        wr_reg(`REG_DELAY, 8'h00);
        wr_reg(`REG_EXT2, 8'h03);
        trig(1'b0);
        idle(20);
        #1 chk("period ignored", 1'b0, sampling);
        trig(1'b1);
        measure(ns, nc, nt, f0);
        chk("duty start", 4, ns);
        wr_reg(`REG_CTRL1, 8'h02);
        wr_reg(`REG_EXT2, 8'h01);
        trig(1'b0);
        idle(24);
        trig(1'b0);
        measure(ns, nc, nt, f0);
        chk("retrigger", 0, ns);
        print_verdict();
    end
endmodule
